// File: logic/pirq_enable_status.v
`timescale 1ns/1ps
`default_nettype none
`include "pirq_defs.vh"

module pirq_enable_status (
    input wire clk_in, // 20 mhz system clock
    input wire rst_n_in, // async reset, active low
    input wire [7:0] addr_in, // register address
    input wire [7:0] wr_data_in, // register write data
    input wire wr_in, // write strobe
    input wire rd_in, // read strobe
    input wire [4:0] capcomp_req_in, // capture/compare channel flags
    input wire [7:0] misc_req_in, // scanner..wavegen flags, bit layout as enable
    input wire [5:0] meas_req_in, // measurement timer flags, layout as enable
    input wire tmr0_ovf_in, // timer-zero overflow pulse
    input wire [4:0] port_edge_flags_in, // per-port pin-change edge flags
    input wire [7:0] gpio_in, // general-purpose pin levels
    output reg [7:0] rd_data_out, // read data, cycle after read strobe
    output reg periph_irq_req_out // interrupt request to the core
);
    // ****************************************
    // registers
    // ****************************************
    reg [4:0] capcomp_irq_enable; // capture/compare enables
    reg [7:0] misc_periph_irq_enable; // scanner..wavegen enables
    reg [5:0] meas_timer_irq_enable; // measurement timer enables
    reg timer_zero_overflow_flag; // sticky timer-zero flag
    reg ext_pin_irq_flag; // sticky external pin flag
    reg periph_irq_gate; // peripheral interrupt gate
    reg global_irq_gate; // global interrupt gate
    reg [2:0] ext_pin_select; // external pin source select
    reg [7:0] status_irq_enable; // enables for status flags

    // ****************************************
    // decode and next values
    // ****************************************
    wire wr_capcomp; // write to capture/compare enables
    wire wr_misc; // write to misc enables
    wire wr_meas; // write to measurement enables
    wire wr_status; // write to status register
    wire wr_control; // write to control register
    wire wr_pin_sel; // write to pin select
    wire wr_status_en; // write to status enables
    wire ext_edge; // external pin event pulse
    wire pin_change_summary_flag; // or of port edge flags
    wire next_tmr0_flag; // next timer-zero flag
    wire next_ext_flag; // next external pin flag
    wire [7:0] status_view; // status register as read
    wire [17:0] pend_flags; // every gated peripheral flag
    wire [17:0] pend_enables; // matching enables
    wire [17:0] pending; // flag and enable per source
    wire [7:0] status_pend; // status flags masked by enable
    reg [7:0] read_mux; // selected read value
    reg next_req; // next interrupt request

    // address decode, writes need the strobe
    // reads need no decode here, the read mux takes the address as is
    assign wr_capcomp = wr_in && (addr_in == `PIRQ_OFS_CAPCOMP_EN);
    assign wr_misc = wr_in && (addr_in == `PIRQ_OFS_MISC_EN);
    assign wr_meas = wr_in && (addr_in == `PIRQ_OFS_MEAS_EN);
    assign wr_status = wr_in && (addr_in == `PIRQ_OFS_STATUS);
    assign wr_control = wr_in && (addr_in == `PIRQ_OFS_CONTROL);
    assign wr_pin_sel = wr_in && (addr_in == `PIRQ_OFS_PIN_SEL);
    assign wr_status_en = wr_in && (addr_in == `PIRQ_OFS_STATUS_EN);

    // ****************************************
    // external pin source
    // ****************************************
    // the chosen gpio feeds an edge detector
    // only a low-to-high change of the chosen pin counts
    // moving the select onto a pin that is high may count as one edge
    pirq_ext_pin_sel u_ext_sel (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .gpio_in(gpio_in),
        .sel_in(ext_pin_select),
        .edge_out(ext_edge)
    );

    // ****************************************
    // status flags
    // ****************************************
    // summary is live, not stored; no write reaches it
    // software clears it by clearing every port edge flag
    assign pin_change_summary_flag = |port_edge_flags_in;

    // a written one sets a flag, a written zero clears it
    // set wins over a software write of zero in the same cycle
    assign next_tmr0_flag = tmr0_ovf_in |
        (wr_status ? wr_data_in[`PIRQ_BIT_TMR0_FLAG] : timer_zero_overflow_flag);
    assign next_ext_flag = ext_edge |
        (wr_status ? wr_data_in[`PIRQ_BIT_EXT_FLAG] : ext_pin_irq_flag);

    // assemble status with unused bits at zero
    assign status_view = {2'h0, timer_zero_overflow_flag,
        pin_change_summary_flag, 3'h0, ext_pin_irq_flag};

    // flags update with no enable in their path
    // neither the enables nor the gates hold a flag back
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            timer_zero_overflow_flag <= 1'b0;
            ext_pin_irq_flag <= 1'b0;
        end else begin
            timer_zero_overflow_flag <= next_tmr0_flag;
            ext_pin_irq_flag <= next_ext_flag;
        end
    end

    // ****************************************
    // enable registers
    // ****************************************
    // only implemented bits are stored
    // unimplemented positions read zero; misc bit 3 has a flop that the mask keeps at zero
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            capcomp_irq_enable <= 5'h00;
            misc_periph_irq_enable <= `PIRQ_RST_BYTE;
            meas_timer_irq_enable <= 6'h00;
        end else begin
            // capture/compare channel 1 at bit 0 up to 5 at bit 4
            if (wr_capcomp) begin
                capcomp_irq_enable <= wr_data_in[4:0];
            end
            // bit 3 is dropped by the mask
            if (wr_misc) begin
                misc_periph_irq_enable <= wr_data_in & `PIRQ_MASK_MISC;
            end
            // top two bits are not stored
            if (wr_meas) begin
                meas_timer_irq_enable <= wr_data_in[5:0];
            end
        end
    end

    // ****************************************
    // control, pin select and status enables
    // ****************************************
    // gates, pin source and status flag enables
    // other control bits are not kept here and read zero
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            periph_irq_gate <= 1'b0;
            global_irq_gate <= 1'b0;
            ext_pin_select <= `PIRQ_RST_SEL;
            status_irq_enable <= `PIRQ_RST_BYTE;
        end else begin
            // both gates live in the control register
            if (wr_control) begin
                periph_irq_gate <= wr_data_in[`PIRQ_BIT_PERIPH_GATE];
                global_irq_gate <= wr_data_in[`PIRQ_BIT_GLOBAL_GATE];
            end
            // pin index for the external source
            if (wr_pin_sel) begin
                ext_pin_select <= wr_data_in[2:0];
            end
            // enables share the status bit layout
            if (wr_status_en) begin
                status_irq_enable <= wr_data_in & `PIRQ_MASK_STATUS;
            end
        end
    end

    // ****************************************
    // request combine
    // ****************************************
    // one named enable per source, in its register bit place
    wire capcomp1_irq_en = capcomp_irq_enable[0];
    wire capcomp2_irq_en = capcomp_irq_enable[1]; // channel 2
    wire capcomp3_irq_en = capcomp_irq_enable[2]; // channel 3
    wire capcomp4_irq_en = capcomp_irq_enable[3]; // channel 4
    wire capcomp5_irq_en = capcomp_irq_enable[4]; // channel 5
    // scanner and checksum at the top of the misc register
    wire mem_scanner_irq_en = misc_periph_irq_enable[`PIRQ_BIT_SCANNER];
    wire checksum_irq_en = misc_periph_irq_enable[`PIRQ_BIT_CHECKSUM];
    // nonvolatile task and oscillator rollover below them
    wire nonvol_task_irq_en = misc_periph_irq_enable[`PIRQ_BIT_NONVOL];
    wire osc_rollover_irq_en = misc_periph_irq_enable[`PIRQ_BIT_OSC_ROLL];
    // wave generators 3..1 at bits 2..0
    wire wavegen3_irq_en = misc_periph_irq_enable[`PIRQ_BIT_WAVEGEN3];
    wire wavegen2_irq_en = misc_periph_irq_enable[`PIRQ_BIT_WAVEGEN2];
    wire wavegen1_irq_en = misc_periph_irq_enable[`PIRQ_BIT_WAVEGEN1];
    // timer 1 in the low three bits
    wire meas1_overflow_irq_en = meas_timer_irq_enable[`PIRQ_BIT_MEAS1_OVF];
    wire meas1_period_irq_en = meas_timer_irq_enable[`PIRQ_BIT_MEAS1_PER];
    wire meas1_pulsewidth_irq_en = meas_timer_irq_enable[`PIRQ_BIT_MEAS1_PW];
    // timer 2 above it, overflow lowest
    wire meas2_overflow_irq_en = meas_timer_irq_enable[`PIRQ_BIT_MEAS2_OVF];
    wire meas2_period_irq_en = meas_timer_irq_enable[`PIRQ_BIT_MEAS2_PER];
    wire meas2_pulsewidth_irq_en = meas_timer_irq_enable[`PIRQ_BIT_MEAS2_PW];

    // peripheral sources, each flag beside its enable
    assign pend_flags = {meas_req_in, misc_req_in[7:4],
        misc_req_in[2:0], capcomp_req_in};
    assign pend_enables = {meas2_pulsewidth_irq_en, meas2_period_irq_en, meas2_overflow_irq_en,
        meas1_pulsewidth_irq_en, meas1_period_irq_en, meas1_overflow_irq_en,
        mem_scanner_irq_en, checksum_irq_en, nonvol_task_irq_en, osc_rollover_irq_en,
        wavegen3_irq_en, wavegen2_irq_en, wavegen1_irq_en, capcomp5_irq_en,
        capcomp4_irq_en, capcomp3_irq_en, capcomp2_irq_en, capcomp1_irq_en};

    // one and-gate per source
    genvar gi;
    generate
        for (gi = 0; gi < 18; gi = gi + 1) begin : g_pend
            assign pending[gi] = pend_flags[gi] & pend_enables[gi];
        end
    endgenerate

    // status flags need only their enable and the global gate
    // the peripheral gate covers only the three enable registers
    assign status_pend = status_view & status_irq_enable;

    // request follows flags, enables and both gates
    always @* begin
        next_req = 1'b0;
        // peripheral group needs the peripheral gate
        if (global_irq_gate && periph_irq_gate && (|pending)) begin
            next_req = 1'b1;
        end
        // status group bypasses the peripheral gate
        if (global_irq_gate && (|status_pend)) begin
            next_req = 1'b1;
        end
    end

    // registered request to the core
    // a flop keeps the request free of decode glitches
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            periph_irq_req_out <= 1'b0;
        end else begin
            periph_irq_req_out <= next_req;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    // select the addressed register, zero padded
    always @* begin
        case (addr_in)
            `PIRQ_OFS_CAPCOMP_EN: begin
                // five channel enables, top three bits zero
                read_mux = {3'h0, capcomp_irq_enable};
            end
            `PIRQ_OFS_MISC_EN: begin
                // the mask keeps bit 3 at zero, so it reads zero
                read_mux = misc_periph_irq_enable;
            end
            `PIRQ_OFS_MEAS_EN: begin
                // six timer enables, top two bits zero
                read_mux = {2'h0, meas_timer_irq_enable};
            end
            `PIRQ_OFS_STATUS: begin
                // sticky flags plus the live summary
                read_mux = status_view;
            end
            `PIRQ_OFS_CONTROL: begin
                // only the two gates are kept here
                read_mux = {global_irq_gate, periph_irq_gate, 6'h00};
            end
            `PIRQ_OFS_PIN_SEL: begin
                // pin index in the low three bits
                read_mux = {5'h00, ext_pin_select};
            end
            `PIRQ_OFS_STATUS_EN: begin
                read_mux = status_irq_enable;
            end
            default: begin
                // unmapped addresses read zero
                read_mux = 8'h00;
            end
        endcase
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= 8'h00;
        end else if (rd_in) begin
            rd_data_out <= read_mux;
        end else begin
            rd_data_out <= 8'h00;
        end
    end
endmodule // pirq_enable_status
`default_nettype wire

// File: logic/pirq_defs.vh
`ifndef PIRQ_DEFS_VH
`define PIRQ_DEFS_VH
// ****************************************
// register offsets
// ****************************************
`define PIRQ_OFS_CAPCOMP_EN 8'h00
`define PIRQ_OFS_MISC_EN 8'h01
`define PIRQ_OFS_MEAS_EN 8'h02
`define PIRQ_OFS_STATUS 8'h03
`define PIRQ_OFS_CONTROL 8'h04
`define PIRQ_OFS_PIN_SEL 8'h05
`define PIRQ_OFS_STATUS_EN 8'h06
// ****************************************
// implemented bit masks
// ****************************************
`define PIRQ_MASK_CAPCOMP 8'h1f
`define PIRQ_MASK_MISC 8'hf7
`define PIRQ_MASK_MEAS 8'h3f
`define PIRQ_MASK_STATUS 8'h31
`define PIRQ_MASK_CONTROL 8'hc0
`define PIRQ_MASK_PIN_SEL 8'h07
// ****************************************
// field positions
// ****************************************
`define PIRQ_BIT_TMR0_FLAG 5
`define PIRQ_BIT_PIN_CHANGE 4
`define PIRQ_BIT_EXT_FLAG 0
`define PIRQ_BIT_GLOBAL_GATE 7
`define PIRQ_BIT_PERIPH_GATE 6
`define PIRQ_BIT_SCANNER 7
`define PIRQ_BIT_CHECKSUM 6
`define PIRQ_BIT_NONVOL 5
`define PIRQ_BIT_OSC_ROLL 4
`define PIRQ_BIT_WAVEGEN3 2
`define PIRQ_BIT_WAVEGEN2 1
`define PIRQ_BIT_WAVEGEN1 0
`define PIRQ_BIT_MEAS1_OVF 0
`define PIRQ_BIT_MEAS1_PER 1
`define PIRQ_BIT_MEAS1_PW 2
`define PIRQ_BIT_MEAS2_OVF 3
`define PIRQ_BIT_MEAS2_PER 4
`define PIRQ_BIT_MEAS2_PW 5
// ****************************************
// reset values
// ****************************************
`define PIRQ_RST_BYTE 8'h00
`define PIRQ_RST_SEL 3'h0
`endif

// File: logic/pirq_ext_pin_sel.v
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// external pin select and edge detect
// ****************************************
module pirq_ext_pin_sel (
    input wire clk_in, // system clock
    input wire rst_n_in, // async reset, active low
    input wire [7:0] gpio_in, // general-purpose pin levels
    input wire [2:0] sel_in, // which pin feeds the external irq
    output reg edge_out // one-cycle pulse on rising edge
);
    reg sel_level; // previous level of the chosen pin
    wire cur_level; // chosen pin now

    // pick the pin named by the select field
    assign cur_level = gpio_in[sel_in];

    // remember level, pulse on a low-to-high change
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sel_level <= 1'b0;
            edge_out <= 1'b0;
        end else begin
            sel_level <= cur_level;
            edge_out <= cur_level & ~sel_level;
        end
    end
endmodule // pirq_ext_pin_sel
`default_nettype wire

// File: test/pirq_enable_status_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "pirq_defs.vh"
// ****************************************
// register port and request checks
// ****************************************
module pirq_chk (
    input wire logic clk_in, // clock
    input wire logic rst_n_in, // reset
    input wire logic [7:0] addr_in, // address
    input wire logic [7:0] wr_data_in, // write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    input wire logic [4:0] capcomp_req_in, // channel flags
    input wire logic [7:0] misc_req_in, // misc flags
    input wire logic [5:0] meas_req_in, // timer flags
    input wire logic tmr0_ovf_in, // overflow
    input wire logic [4:0] port_edge_flags_in, // edge flags
    input wire logic [7:0] gpio_in, // pins
    input wire logic [7:0] rd_data_out, // read data
    input wire logic periph_irq_req_out // request
);
    logic [7:0] sh_ctl, sh_cc, sh_sten, sh_sel; // copies of written registers
    // follow the writes that the checks lean on
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {sh_ctl, sh_cc, sh_sten, sh_sel} <= 32'h0000_0000;
        end else if (wr_in) begin
            case (addr_in)
                `PIRQ_OFS_CONTROL: sh_ctl <= wr_data_in & `PIRQ_MASK_CONTROL;
                `PIRQ_OFS_CAPCOMP_EN: sh_cc <= wr_data_in & `PIRQ_MASK_CAPCOMP;
                `PIRQ_OFS_STATUS_EN: sh_sten <= wr_data_in & 8'h31;
                `PIRQ_OFS_PIN_SEL: sh_sel <= wr_data_in & `PIRQ_MASK_PIN_SEL;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_rd(logic [7:0] a); rd_in && addr_in == a; endsequence
    sequence s_rise; !gpio_in[sh_sel[2:0]] ##1 gpio_in[sh_sel[2:0]]; endsequence
    AST_RST_CLEAR: assert property ($rose(rst_n_in) |-> rd_data_out == 8'h00 && !periph_irq_req_out)
        else $error("outputs set after reset");
    AST_READ_IDLE: assert property (!rd_in |=> rd_data_out == 8'h00)
        else $error("read data outside a read");
    AST_CC_READ: assert property (s_rd(`PIRQ_OFS_CAPCOMP_EN) |=> rd_data_out == $past(sh_cc))
        else $error("channel enables read wrong");
    AST_SUMMARY: assert property (s_rd(`PIRQ_OFS_STATUS) |=> rd_data_out[4] == |$past(port_edge_flags_in))
        else $error("summary flag wrong");
    AST_TMR0_SET: assert property (tmr0_ovf_in ##2 s_rd(`PIRQ_OFS_STATUS) |=> rd_data_out[5])
        else $error("overflow flag not set");
    AST_EXT_SET: assert property (s_rise ##3 s_rd(`PIRQ_OFS_STATUS) |=> rd_data_out[0])
        else $error("pin flag not set");
    AST_GLOBAL: assert property (periph_irq_req_out |-> $past(sh_ctl[7]))
        else $error("request without global gate");
    AST_PERIPH: assert property (periph_irq_req_out && $past(sh_sten) == 8'h00 |-> $past(sh_ctl[6]))
        else $error("request without peripheral gate");
    AST_RAISE: assert property (sh_ctl[7:6] == 2'b11 && |(capcomp_req_in & sh_cc[4:0]) |=> periph_irq_req_out)
        else $error("request missing");
endmodule // pirq_chk
bind pirq_enable_status pirq_chk u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .capcomp_req_in(capcomp_req_in),
    .misc_req_in(misc_req_in), .meas_req_in(meas_req_in), .tmr0_ovf_in(tmr0_ovf_in),
    .port_edge_flags_in(port_edge_flags_in), .gpio_in(gpio_in), .rd_data_out(rd_data_out),
    .periph_irq_req_out(periph_irq_req_out));
`default_nettype wire

// File: test/pirq_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// peripherals raising requests
// ****************************************
module pirq_periph_model (
    input wire logic clk_in, // clock
    output logic [4:0] capcomp_out, // channel flags
    output logic [7:0] misc_out, // misc flags
    output logic [5:0] meas_out, // timer flags
    output logic [4:0] port_edge_out, // edge flags
    output logic [7:0] gpio_out, // pins
    output logic tmr0_out // overflow pulse
);
    // all quiet at power-up
    initial begin
        {capcomp_out, misc_out, meas_out, port_edge_out, gpio_out, tmr0_out} = 33'h0_0000_0000;
    end
    // new levels just after an edge; edge flags drop only here
    task automatic levels(input logic [4:0] c, input logic [7:0] m, input logic [5:0] t,
        input logic [4:0] p, input logic [7:0] g);
        @(posedge clk_in);
        {capcomp_out, misc_out, meas_out, port_edge_out, gpio_out} <= {c, m, t, p, g};
    endtask
    // one-cycle overflow
    task automatic overflow();
        @(posedge clk_in);
        tmr0_out <= 1'b1;
        @(posedge clk_in);
        tmr0_out <= 1'b0;
    endtask
endmodule // pirq_periph_model
`default_nettype wire

// File: test/periph_irq_enable_status_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench with register model
// ****************************************
module periph_irq_enable_status_tb_top;
    logic clk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0; // clock, reset, strobes
    logic [7:0] addr_in = 8'h00, wr_data_in = 8'h00; // bus
    wire logic [4:0] cc, pef; // channel and edge flags
    wire logic [7:0] misc, gpio, rd_data_out; // flags, pins, read data
    wire logic [5:0] meas; // timer flags
    wire logic tmr0, periph_irq_req_out; // overflow, request
    logic [7:0] mreg [0:7]; // model registers
    logic [7:0] wmask [0:7] = '{8'h1f, 8'hf7, 8'h3f, 8'h21, 8'hc0, 8'h07, 8'h31, 8'h00}; // writable bits
    int bad_count = 0, comparisons = 0, cycles = 0, seed = 32'hab3f7ed7; // counters, seed
    logic [7:0] ra; // random address
    always #25 clk_in = ~clk_in;
    pirq_periph_model partner (.clk_in(clk_in), .capcomp_out(cc), .misc_out(misc), .meas_out(meas),
        .port_edge_out(pef), .gpio_out(gpio), .tmr0_out(tmr0));
    pirq_enable_status dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .wr_in(wr_in), .rd_in(rd_in), .capcomp_req_in(cc), .misc_req_in(misc), .meas_req_in(meas),
        .tmr0_ovf_in(tmr0), .port_edge_flags_in(pef), .gpio_in(gpio), .rd_data_out(rd_data_out),
        .periph_irq_req_out(periph_irq_req_out));
    // compare and count
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            $display("unexpected %s: expected %h, seen %h", n, e, s);
            bad_count++;
        end
    endtask
    // print verdict and stop
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // reset held three cycles, model cleared
    task automatic do_reset();
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        foreach (mreg[i]) mreg[i] = 8'h00;
    endtask
    // one-cycle write, model follows
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        {addr_in, wr_data_in, wr_in} <= {a, d, 1'b1};
        @(posedge clk_in);
        wr_in <= 1'b0;
        if (a < 8'h07) mreg[a[2:0]] = d & wmask[a[2:0]];
    endtask
    // one-cycle read, data checked in the next cycle
    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        @(posedge clk_in);
        {addr_in, rd_in} <= {a, 1'b1};
        @(posedge clk_in);
        rd_in <= 1'b0;
        e = (a < 8'h07) ? mreg[a[2:0]] : 8'h00;
        if (a == 8'h03) e[4] = |pef;
        @(negedge clk_in);
        chk("read data", e, rd_data_out);
    endtask
    // request against gates, enables and flags
    task automatic chkreq();
        logic p, s;
        p = |{cc & mreg[0][4:0], misc & mreg[1], meas & mreg[2][5:0]};
        s = |({mreg[3][7:5], |pef, mreg[3][3:0]} & mreg[6]);
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
        chk("request", {7'h00, mreg[4][7] & (mreg[4][6] & p | s)}, {7'h00, periph_irq_req_out});
    endtask
    // cut a hang short
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            test_done();
        end
    end
    // main sequence
    initial begin
        do_reset();
        for (int a = 0; a < 9; a++) rd(8'(a));
        for (int a = 0; a < 8; a++) begin
            wr(8'(a), 8'hff);
            rd(8'(a));
        end
        rd(8'hff);
        for (int i = 0; i < 24; i++) begin
            partner.levels(5'($random(seed)), 8'($random(seed)), 6'($random(seed)), 5'($random(seed)), 8'h00);
            wr(8'($random(seed)) & 8'h07, 8'($random(seed)));
            ra = 8'($random(seed)) & 8'h07;
            rd(ra);
            chkreq();
        end
        do_reset();
        for (int a = 0; a < 7; a++) rd(8'(a));
        partner.levels(5'h00, 8'h00, 6'h00, 5'h04, 8'h00);
        wr(8'h03, 8'h10);
        rd(8'h03);
        partner.levels(5'h00, 8'h00, 6'h00, 5'h00, 8'h00);
        rd(8'h03);
        partner.overflow();
        mreg[3][5] = 1'b1;
        rd(8'h03);
        wr(8'h03, 8'h00);
        rd(8'h03);
        wr(8'h05, 8'h03);
        partner.levels(5'h00, 8'h00, 6'h00, 5'h00, 8'h20);
        repeat (2) @(posedge clk_in);
        rd(8'h03);
        partner.levels(5'h00, 8'h00, 6'h00, 5'h00, 8'h28);
        repeat (2) @(posedge clk_in);
        mreg[3][0] = 1'b1;
        rd(8'h03);
        wr(8'h03, 8'h00);
        rd(8'h03);
        wr(8'h00, 8'h01);
        partner.levels(5'h01, 8'h00, 6'h00, 5'h00, 8'h28);
        for (int g = 0; g < 4; g++) begin
            wr(8'h04, 8'(g << 6));
            chkreq();
        end
        test_done();
    end
endmodule // periph_irq_enable_status_tb_top
`default_nettype wire
